// >>> src/cbh_pkg.sv
// Constants for the card-buffer head and row synchronizer
package cbh_pkg;
	localparam logic [3:0] PH_T1  = 4'h1;
	localparam logic [3:0] PH_T2  = 4'h2;
	localparam logic [3:0] PH_T3  = 4'h3;
	localparam logic [3:0] PH_T7  = 4'h7;
	localparam logic [3:0] PH_T8  = 4'h8;
	localparam logic [3:0] PH_T10 = 4'hA;
	localparam logic [3:0] PH_T11 = 4'hB;
	localparam int BAND_WORDS = 200;
	localparam int HALF_WORDS = 100;
	localparam int READ_SETS  = 20;
	localparam logic [2:0] ROW_CLEAR = 3'h0;
	localparam logic [2:0] ROW_ONE   = 3'h1;
	localparam logic [2:0] ROW_TWO   = 3'h2;
	localparam logic [2:0] ROW_THREE = 3'h3;
	localparam logic [2:0] ROW_FOUR  = 3'h4;
	localparam logic [2:0] ROW_FIVE  = 3'h5;
	localparam logic [2:0] ROW_SIX   = 3'h6;
	localparam logic [7:0] LOC_RESET = 8'h00;
	localparam logic [4:0] CNT_RESET = 5'h00;

	typedef struct packed {
		logic [3:0] phase;
		logic [7:0] loc;
		logic       gap_meta;
		logic       gap_sync;
		logic       gap_prev;
		logic       gap_pend;
		logic       ph_meta;
		logic       ph_sync;
		logic       ph_prev;
		logic       ph_pend;
		logic       sync1;
		logic       sync2;
		logic [2:0] row;
		logic       lower;
		logic       h1_read;
		logic       h2_read;
		logic [4:0] h1_cnt;
		logic [4:0] h2_cnt;
		logic       mem_trig;
		logic       h2_write;
		logic [3:0] trk_en;
		logic [3:0] trk_dat;
		logic       counter_reset_pulse;
		logic       card_cycle_step;
		logic       src;
	} cbh_state_t;
endpackage : cbh_pkg

// >>> src/cbh_card_buffer.sv
// Card-buffer head control and timing-disc row synchronizer
// Functional notes
// R01: Buffer transfer sets head 1 read on reader half plus first sentinel, twenty times.
// R02: Head 1 read set triggers storage write; its enable opens head 1 read gates.
// R03: Head 2 write sets like head 1 but needs punch-half flag; cleared at t1B.
// R04: Data and both coder gates open writes data; all closed nothing; coder only zeros.
// R05: Shift register line carries zero as high level, one as low level.
// R06: Row one or five writes bit to track 1; track 2 untouched; 3,4 zeros.
// R07: Row two or six writes bit to track 2; track 1 untouched; 3,4 zeros.
// R08: Row three writes bit to track 3; track 4 zeros; tracks 1,2 untouched.
// R09: Row four writes bit to track 4; tracks 1 to 3 untouched.
// R10: Buffer transfer sets head 2 read on punch half plus second sentinel, twenty times.
// R11: Head 2 read set triggers storage write; its enable opens head 2 read gates.
// R12: Gap clear-counter signal sets sync flip-flop 1 at t8B of alternate word.
// R13: Alternate words are every second band word starting at location 001.
// R14: Next alternate word t7B clears row counter and restores sync flip-flop 2.
// R15: Same word t8B forces row twelve: count six, lower field.
// R16: Forcing pulse gives counter reset, restores sync 1, asserts card-cycle step.
// R17: Photocell sets sync 2 at t10B alternate; step gate fires next alternate t10B.
// R18: Step gate output is step-row pulse; row twelve advances to row one.
// R19: Sync flip-flop 2 restores after each step, ready for next photocell.
// R20: Head flags tell which buffer half lies under head 1.
// R21: Counts one to six upper field mean rows 1-6; lower field rows 7-12.
// R22: Word timing is phases t1B to t11B; alternate-word flag toggles each word.
//
`timescale 1ns/10ps
module cbh_card_buffer #(
	parameter int NUM_WORDS = cbh_pkg::BAND_WORDS,
	parameter int NUM_READS = cbh_pkg::READ_SETS
) (
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	input  wire logic       BUFFER_TRANSFER_FUNCTION,
	input  wire logic       FIRST_HALF_READ_SENTINEL,
	input  wire logic       SECOND_HALF_READ_SENTINEL,
	input  wire logic [3:0] WRITE_SENTINEL,
	input  wire logic       SHIFT_OUT_ACTIVE,
	input  wire logic       SHIFT_REGISTER_OUT_LINE,
	input  wire logic       CLEAR_COUNTER,
	input  wire logic       PHOTOCELL,
	output logic [3:0]      WORD_PHASE,
	output logic [7:0]      BAND_LOCATION,
	output logic            ALTERNATE_WORD,
	output logic            READER_HALF_UNDER_HEAD_ONE,
	output logic            PUNCH_HALF_UNDER_HEAD_ONE,
	output logic            HEAD_ONE_READ_SET,
	output logic            HEAD_ONE_READ_OUTPUT_ENABLE,
	output logic            HEAD_TWO_READ_SET,
	output logic            HEAD_TWO_READ_OUTPUT_ENABLE,
	output logic            STORAGE_WRITE_TRIGGER,
	output logic            HEAD_TWO_WRITE,
	output logic [3:0]      TRACK_WRITE_ENABLE,
	output logic [3:0]      TRACK_WRITE_DATA,
	output logic [2:0]      ROW_COUNT,
	output logic            LOWER_FIELD_FLAG,
	output logic            UPPER_FIELD_FLAG,
	output logic            COUNTER_RESET_PULSE,
	output logic            CARD_CYCLE_STEP,
	output logic            STEP_ROW_PULSE,
	output logic            PICKERKNIFE_RESTORE_ENABLE
);
	cbh_pkg::cbh_state_t st;
	cbh_pkg::cbh_state_t next_st;

	logic ew;
	logic reader_half;
	logic punch_half;
	logic gap_edge;
	logic ph_edge;
	logic row_one_or_five;
	logic row_two_or_six;
	logic row_three;
	logic row_four;
	logic rows_low;
	logic rows_high;
	logic write_cond;
	logic h1_set;
	logic h2_set;
	logic clear_gate;
	logic force_gate;
	logic step_gate;
	logic sr_bit;
	logic data_open;
	logic [3:0] coder_open;
	logic [3:0] data_gate;

	// R13: odd band locations, so location 001 is the first alternate word
	assign ew = st.loc[0];
	// R20: lower half of the band is the reader half
	assign reader_half = (32'(st.loc) < cbh_pkg::HALF_WORDS);
	assign punch_half  = !reader_half;
	// Only the second and third stages are looked at; the first may be metastable
	assign gap_edge = st.gap_sync && !st.gap_prev;
	assign ph_edge  = st.ph_sync && !st.ph_prev;

	// R21: count plus field flag name the card row
	assign row_one_or_five = (st.row == cbh_pkg::ROW_ONE) || (st.row == cbh_pkg::ROW_FIVE);
	assign row_two_or_six  = (st.row == cbh_pkg::ROW_TWO) || (st.row == cbh_pkg::ROW_SIX);
	assign row_three       = (st.row == cbh_pkg::ROW_THREE);
	assign row_four        = (st.row == cbh_pkg::ROW_FOUR);
	assign rows_low  = (st.row >= cbh_pkg::ROW_ONE) && (st.row <= cbh_pkg::ROW_FOUR);
	assign rows_high = row_one_or_five && !(st.row == cbh_pkg::ROW_ONE) ||
		(st.row == cbh_pkg::ROW_SIX);
	// R03: write sentinel bits gated by row group and field
	assign write_cond = (WRITE_SENTINEL[0] && rows_low && !st.lower) ||
		(WRITE_SENTINEL[1] && rows_high && !st.lower) ||
		(WRITE_SENTINEL[2] && rows_low && st.lower) ||
		(WRITE_SENTINEL[3] && rows_high && st.lower);

	// R01: reader half with the first-half sentinel
	assign h1_set = BUFFER_TRANSFER_FUNCTION && reader_half && FIRST_HALF_READ_SENTINEL &&
		(st.phase == cbh_pkg::PH_T2) && (32'(st.h1_cnt) < NUM_READS) && !st.h1_read;
	// R10: punch half with the second-half sentinel
	assign h2_set = BUFFER_TRANSFER_FUNCTION && punch_half && SECOND_HALF_READ_SENTINEL &&
		(st.phase == cbh_pkg::PH_T2) && (32'(st.h2_cnt) < NUM_READS) && !st.h2_read;

	// R14: t7B of the alternate word after sync 1 was set
	assign clear_gate = st.sync1 && ew && (st.phase == cbh_pkg::PH_T7);
	// R15: t8B of the same alternate word
	assign force_gate = st.sync1 && ew && (st.phase == cbh_pkg::PH_T8);
	// R17: sync 2 was set on an earlier alternate word
	assign step_gate  = st.sync2 && ew && (st.phase == cbh_pkg::PH_T10);

	// R05: line is active low for a one bit
	assign sr_bit    = !SHIFT_REGISTER_OUT_LINE;
	assign data_open = punch_half && SHIFT_OUT_ACTIVE;
	// R06: track 1 gates on row one or five
	// R07: track 2 gates on row two or six
	// R08: track 3 coder opens unless row four
	// R09: track 4 coder needs no row signal
	assign coder_open = {st.h2_write, st.h2_write && !row_four,
		st.h2_write && row_two_or_six, st.h2_write && row_one_or_five};
	assign data_gate  = {row_four, row_three, row_two_or_six, row_one_or_five} &
		{4{data_open}};

	always_comb
	begin
		next_st = st;
		// R22: eleven phases per word, band location advances after t11B
		if (st.phase == cbh_pkg::PH_T11)
		begin
			next_st.phase = cbh_pkg::PH_T1;
			if (32'(st.loc) == NUM_WORDS - 1)
				next_st.loc = cbh_pkg::LOC_RESET;
			else
				next_st.loc = st.loc + 8'h01;
		end
		else
			next_st.phase = st.phase + 4'h1;

		next_st.gap_meta = CLEAR_COUNTER;
		next_st.gap_sync = st.gap_meta;
		next_st.gap_prev = st.gap_sync;
		next_st.ph_meta  = PHOTOCELL;
		next_st.ph_sync  = st.ph_meta;
		next_st.ph_prev  = st.ph_sync;
		next_st.counter_reset_pulse      = 1'b0;
		next_st.card_cycle_step     = 1'b0;
		next_st.src      = 1'b0;
		next_st.mem_trig = 1'b0;

		// R01: read counts restart with each transfer instruction
		if (!BUFFER_TRANSFER_FUNCTION)
		begin
			next_st.h1_cnt = cbh_pkg::CNT_RESET;
			next_st.h2_cnt = cbh_pkg::CNT_RESET;
		end
		// R02: restore late in the word, still inside the transfer
		if (st.phase == cbh_pkg::PH_T11 || !BUFFER_TRANSFER_FUNCTION)
		begin
			next_st.h1_read = 1'b0;
			next_st.h2_read = 1'b0;
		end
		// R02: set triggers the main-storage write flip-flop
		if (h1_set)
		begin
			next_st.h1_read  = 1'b1;
			next_st.h1_cnt   = st.h1_cnt + 5'h01;
			next_st.mem_trig = 1'b1;
		end
		// R11: same path for head 2
		if (h2_set)
		begin
			next_st.h2_read  = 1'b1;
			next_st.h2_cnt   = st.h2_cnt + 5'h01;
			next_st.mem_trig = 1'b1;
		end

		// R03: restore at t1B, set at t3B over the punch half
		if (st.phase == cbh_pkg::PH_T1)
			next_st.h2_write = 1'b0;
		else if (st.phase == cbh_pkg::PH_T3 && punch_half && write_cond)
			next_st.h2_write = 1'b1;

		// R04: coder only gives zeros, coder plus data gives the bit
		next_st.trk_en  = coder_open;
		next_st.trk_dat = coder_open & data_gate & {4{sr_bit}};

		// Gap and photocell edges wait for their alternate-word phase
		if (gap_edge)
			next_st.gap_pend = 1'b1;
		if (ph_edge)
			next_st.ph_pend = 1'b1;

		// R14: clear the three row flip-flops, restore sync 2
		if (clear_gate)
		begin
			next_st.row   = cbh_pkg::ROW_CLEAR;
			next_st.sync2 = 1'b0;
		end
		// R15: jam row twelve
		// R16: reset pulse and card-cycle step, sync 1 restored
		if (force_gate)
		begin
			next_st.row   = cbh_pkg::ROW_SIX;
			next_st.lower = 1'b1;
			next_st.counter_reset_pulse   = 1'b1;
			next_st.card_cycle_step  = 1'b1;
			next_st.sync1 = 1'b0;
		end
		// R18: step row; row twelve wraps to row one upper field
		// R19: restore sync 2 after the step
		if (step_gate)
		begin
			next_st.src   = 1'b1;
			next_st.sync2 = 1'b0;
			if (st.row == cbh_pkg::ROW_SIX)
			begin
				next_st.row   = cbh_pkg::ROW_ONE;
				next_st.lower = !st.lower;
			end
			else
				next_st.row = st.row + 3'h1;
		end
		// R12: set wins over any restore in the same cycle
		if (st.gap_pend && ew && st.phase == cbh_pkg::PH_T8)
		begin
			next_st.sync1    = 1'b1;
			next_st.gap_pend = gap_edge;
		end
		// R17: photocell sets sync 2 at t10B of an alternate word
		if (st.ph_pend && ew && st.phase == cbh_pkg::PH_T10)
		begin
			next_st.sync2   = 1'b1;
			next_st.ph_pend = ph_edge;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			st       <= '0;
			st.phase <= cbh_pkg::PH_T1;
		end
		else
			st <= next_st;
	end

	assign WORD_PHASE                  = st.phase;
	assign BAND_LOCATION               = st.loc;
	assign ALTERNATE_WORD              = ew;
	assign READER_HALF_UNDER_HEAD_ONE  = reader_half;
	assign PUNCH_HALF_UNDER_HEAD_ONE   = punch_half;
	assign HEAD_ONE_READ_SET           = st.h1_read;
	assign HEAD_ONE_READ_OUTPUT_ENABLE = st.h1_read;
	assign HEAD_TWO_READ_SET           = st.h2_read;
	assign HEAD_TWO_READ_OUTPUT_ENABLE = st.h2_read;
	assign STORAGE_WRITE_TRIGGER       = st.mem_trig;
	assign HEAD_TWO_WRITE              = st.h2_write;
	assign TRACK_WRITE_ENABLE          = st.trk_en;
	assign TRACK_WRITE_DATA            = st.trk_dat;
	assign ROW_COUNT                   = st.row;
	assign LOWER_FIELD_FLAG            = st.lower;
	assign UPPER_FIELD_FLAG            = !st.lower;
	assign COUNTER_RESET_PULSE         = st.counter_reset_pulse;
	assign CARD_CYCLE_STEP             = st.card_cycle_step;
	assign STEP_ROW_PULSE              = st.src;
	assign PICKERKNIFE_RESTORE_ENABLE  = st.sync2;

	sequence s_row_cleared;
		st.row == cbh_pkg::ROW_CLEAR;
	endsequence
	sequence s_row_twelve;
		st.row == cbh_pkg::ROW_SIX && st.lower && st.counter_reset_pulse && st.card_cycle_step && !st.sync1;
	endsequence
	sequence s_head1_stands;
		st.phase == cbh_pkg::PH_T3 && st.mem_trig ##8 st.h1_read ##1 !st.h1_read;
	endsequence
	sequence s_head2_stands;
		st.phase == cbh_pkg::PH_T3 && st.mem_trig ##8 st.h2_read ##1 !st.h2_read;
	endsequence

	a_head1_read_set: assert property (@(posedge REF_CLK) disable iff (RST) // R01
		$rose(st.h1_read) |-> $past(FIRST_HALF_READ_SENTINEL && reader_half &&
		st.phase == cbh_pkg::PH_T2))
		else $error("Head 1 read set without its sentinel");
	a_read_trigger: assert property (@(posedge REF_CLK) disable iff (RST) // R02
		$rose(st.h1_read) || $rose(st.h2_read) |-> st.mem_trig)
		else $error("Read set without storage trigger");
	a_write_restore: assert property (@(posedge REF_CLK) disable iff (RST) // R03
		st.phase == cbh_pkg::PH_T1 |=> !st.h2_write [*2])
		else $error("Head 2 write not restored at t1B");
	a_track_one: assert property (@(posedge REF_CLK) disable iff (RST) // R06
		st.h2_write && row_one_or_five |=> st.trk_en == 4'hD && st.trk_dat[3:2] == 2'h0)
		else $error("Track gating wrong for row one or five");
	a_head2_limit: assert property (@(posedge REF_CLK) disable iff (RST) // R10
		$rose(st.h2_read) |-> 32'(st.h2_cnt) <= NUM_READS && $past(punch_half))
		else $error("Head 2 read set out of bounds");
	a_sync1_set: assert property (@(posedge REF_CLK) disable iff (RST) // R12
		$rose(st.sync1) |-> $past(ew && st.phase == cbh_pkg::PH_T8))
		else $error("Sync 1 set off its phase");
	a_row_force: assert property (@(posedge REF_CLK) disable iff (RST) // R15
		clear_gate |=> s_row_cleared ##1 s_row_twelve)
		else $error("Row clear and force sequence broken");
	a_step_wrap: assert property (@(posedge REF_CLK) disable iff (RST) // R18
		step_gate && st.row == cbh_pkg::ROW_SIX && st.lower |=>
		st.src && st.row == cbh_pkg::ROW_ONE && !st.lower)
		else $error("Row twelve did not step to row one");
	a_step_spacing: assert property (@(posedge REF_CLK) disable iff (RST) // R19
		st.src |-> !st.sync2 || $past(st.ph_pend))
		else $error("Sync 2 not restored after step");

	a_head1_limit: assert property (@(posedge REF_CLK) disable iff (RST) // R01
		$rose(st.h1_read) |-> 32'(st.h1_cnt) <= NUM_READS && $past(reader_half))
		else $error("Head 1 read set out of bounds");
	// Ending the instruction may cut a read short, so those words are not judged
	a_head1_stands: assert property (@(posedge REF_CLK) // R02
		disable iff (RST || !BUFFER_TRANSFER_FUNCTION)
		$rose(st.h1_read) |-> s_head1_stands)
		else $error("Head 1 read flop did not stand to t11B");
	a_head2_stands: assert property (@(posedge REF_CLK) // R11
		disable iff (RST || !BUFFER_TRANSFER_FUNCTION)
		$rose(st.h2_read) |-> s_head2_stands)
		else $error("Head 2 read flop did not stand to t11B");
	a_write_set: assert property (@(posedge REF_CLK) disable iff (RST) // R03
		$rose(st.h2_write) |-> $past(st.phase == cbh_pkg::PH_T3 && punch_half && write_cond))
		else $error("Head 2 write set off its gate");

	a_track_idle: assert property (@(posedge REF_CLK) disable iff (RST) // R04
		!st.h2_write |=> st.trk_en == 4'h0 && st.trk_dat == 4'h0)
		else $error("Track written without write flop");
	a_track_zero: assert property (@(posedge REF_CLK) disable iff (RST) // R05
		SHIFT_REGISTER_OUT_LINE |=> st.trk_dat == 4'h0)
		else $error("High line level written as one");
	a_track_data: assert property (@(posedge REF_CLK) disable iff (RST) // R05
		st.h2_write && data_open && !SHIFT_REGISTER_OUT_LINE &&
		st.row != cbh_pkg::ROW_CLEAR |=> st.trk_dat != 4'h0)
		else $error("Low line level not written as one");
	a_track_two: assert property (@(posedge REF_CLK) disable iff (RST) // R07
		st.h2_write && row_two_or_six |=> st.trk_en == 4'hE && st.trk_dat[3:2] == 2'h0 && !st.trk_dat[0])
		else $error("Track gating wrong for row two or six");
	a_track_three: assert property (@(posedge REF_CLK) disable iff (RST) // R08
		st.h2_write && row_three |=> st.trk_en == 4'hC && st.trk_dat[3] == 1'b0)
		else $error("Track gating wrong for row three");
	a_track_four: assert property (@(posedge REF_CLK) disable iff (RST) // R09
		st.h2_write && row_four |=> st.trk_en == 4'h8)
		else $error("Track gating wrong for row four");

	a_word_phase: assert property (@(posedge REF_CLK) disable iff (RST) // R22
		!RST && st.phase != cbh_pkg::PH_T11 |=> st.phase == $past(st.phase) + 4'h1)
		else $error("Word phase skipped");
	a_alt_toggle: assert property (@(posedge REF_CLK) disable iff (RST) // R13
		st.phase == cbh_pkg::PH_T11 |=> ew != $past(ew))
		else $error("Alternate word flag did not toggle");
	a_head_halves: assert property (@(posedge REF_CLK) disable iff (RST) // R20
		st.phase == cbh_pkg::PH_T11 && 32'(st.loc) == cbh_pkg::HALF_WORDS - 1 |=>
		PUNCH_HALF_UNDER_HEAD_ONE && !READER_HALF_UNDER_HEAD_ONE)
		else $error("Head flags did not swap at mid band");

	a_clear_row: assert property (@(posedge REF_CLK) disable iff (RST) // R14
		clear_gate |=> st.row == cbh_pkg::ROW_CLEAR && !st.sync2)
		else $error("Clear gate left row or sync 2 set");
	a_sync1_restore: assert property (@(posedge REF_CLK) disable iff (RST) // R16
		$fell(st.sync1) |-> $past(force_gate))
		else $error("Sync 1 restored without forcing pulse");
	a_sync2_set: assert property (@(posedge REF_CLK) disable iff (RST) // R17
		$rose(st.sync2) |-> $past(st.ph_pend && ew && st.phase == cbh_pkg::PH_T10))
		else $error("Sync 2 set off its phase");
	a_step_gate: assert property (@(posedge REF_CLK) disable iff (RST) // R18
		$rose(st.src) |-> $past(step_gate))
		else $error("Step row pulse without step gate");
endmodule : cbh_card_buffer

// >>> verif/cbh_disc_model.sv
// Timing disc and drum sentinel model facing the card buffer
`timescale 1ns/10ps
module cbh_disc_model #(
	parameter int PERIOD  = 1400,
	parameter int FIRST   = 120,
	parameter int SPACING = 100
) (
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	input  wire logic [3:0] WORD_PHASE,
	output logic            FIRST_HALF_READ_SENTINEL,
	output logic            SECOND_HALF_READ_SENTINEL,
	output logic            CLEAR_COUNTER,
	output logic            PHOTOCELL
);
	int cnt;
	initial
	begin
		cnt = 0;
		FIRST_HALF_READ_SENTINEL = 1'b0;
		SECOND_HALF_READ_SENTINEL = 1'b0;
		CLEAR_COUNTER = 1'b0;
		PHOTOCELL = 1'b0;
	end
	always @(posedge REF_CLK)
	begin
		cnt <= (RST || cnt == PERIOD - 1) ? 0 : cnt + 1;
		// One gap per disc turn
		CLEAR_COUNTER <= !RST && cnt < 8;
		// Twelve notches, spaced beyond one step
		PHOTOCELL <= !RST && cnt >= FIRST && cnt < FIRST + 12 * SPACING
			&& (cnt - FIRST) % SPACING < 4;
		// Sentinels valid at t2B only; toggling junk elsewhere
		FIRST_HALF_READ_SENTINEL <= (WORD_PHASE == cbh_pkg::PH_T1) | cnt[0];
		SECOND_HALF_READ_SENTINEL <= (WORD_PHASE == cbh_pkg::PH_T1) | ~cnt[0];
	end
endmodule : cbh_disc_model

// >>> verif/cbh_card_buffer_tb.sv
// Self-checking bench for the card-buffer head controller
`timescale 1ns/10ps
module cbh_card_buffer_tb;
	logic       ref_clk, rst, func, act, line, s1, s2, gap, pc;
	logic [3:0] wsent, phase, ten, tdat, pph;
	logic [7:0] loc;
	logic [2:0] row, prow, erow;
	logic       alt, rdr, pun, h1s, h1e, h2s, h2e, trig, h2w, low, upp;
	logic       counter_reset_pulse, ccs, srp, pke, ppke, pw, pline, pact, elow, mon_on, row_ok, ppun;
	logic [1:0] e;
	logic [1:0] expq[$];
	logic [31:0] rnd;
	int         errors, num_checks, seed, steps, rpcs;

	cbh_card_buffer cbh_card_buffer_i (.REF_CLK(ref_clk), .RST(rst),
		.BUFFER_TRANSFER_FUNCTION(func), .FIRST_HALF_READ_SENTINEL(s1),
		.SECOND_HALF_READ_SENTINEL(s2), .WRITE_SENTINEL(wsent), .SHIFT_OUT_ACTIVE(act),
		.SHIFT_REGISTER_OUT_LINE(line), .CLEAR_COUNTER(gap), .PHOTOCELL(pc),
		.WORD_PHASE(phase), .BAND_LOCATION(loc), .ALTERNATE_WORD(alt),
		.READER_HALF_UNDER_HEAD_ONE(rdr), .PUNCH_HALF_UNDER_HEAD_ONE(pun),
		.HEAD_ONE_READ_SET(h1s), .HEAD_ONE_READ_OUTPUT_ENABLE(h1e),
		.HEAD_TWO_READ_SET(h2s), .HEAD_TWO_READ_OUTPUT_ENABLE(h2e),
		.STORAGE_WRITE_TRIGGER(trig), .HEAD_TWO_WRITE(h2w), .TRACK_WRITE_ENABLE(ten),
		.TRACK_WRITE_DATA(tdat), .ROW_COUNT(row), .LOWER_FIELD_FLAG(low),
		.UPPER_FIELD_FLAG(upp), .COUNTER_RESET_PULSE(counter_reset_pulse), .CARD_CYCLE_STEP(ccs),
		.STEP_ROW_PULSE(srp), .PICKERKNIFE_RESTORE_ENABLE(pke));
	cbh_disc_model cbh_disc_model_i (.REF_CLK(ref_clk), .RST(rst), .WORD_PHASE(phase),
		.FIRST_HALF_READ_SENTINEL(s1), .SECOND_HALF_READ_SENTINEL(s2),
		.CLEAR_COUNTER(gap), .PHOTOCELL(pc));

	task cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : cmp

	task wrap_up;
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	function logic [7:0] trk_exp(input logic [2:0] r, input logic d);
		case (r)
			3'h0:       trk_exp = {4'hC, 4'h0};
			3'h1, 3'h5: trk_exp = {4'hD, 3'h0, d};
			3'h2, 3'h6: trk_exp = {4'hE, 2'h0, d, 1'h0};
			3'h3:       trk_exp = {4'hC, 1'h0, d, 2'h0};
			default:    trk_exp = {4'h8, d, 3'h0};
		endcase
	endfunction : trk_exp

	// Whole revolution of transfer from a chosen start word
	task xfer(input logic [7:0] start, input logic [1:0] e1, input logic [1:0] e2);
		int n;
		n = 0;
		while (!(loc === start && phase === cbh_pkg::PH_T1) && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (20) expq.push_back(e1);
		repeat (20) expq.push_back(e2);
		func <= 1'b1;
		repeat (cbh_pkg::BAND_WORDS * 11) @(posedge ref_clk);
		func <= 1'b0;
		repeat (30) @(posedge ref_clk);
	endtask : xfer

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial
	begin
		{rst, func, act, line, mon_on, row_ok} = 6'h20;
		wsent = 4'hF;
		{errors, num_checks, steps, rpcs, seed} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd740};
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmp({h1s, h1e, h2s, h2e, trig, h2w, counter_reset_pulse, ccs}, 8'h00, "reset pulses");
		cmp({srp, pke, low, upp, rdr, pun, 2'h0}, 8'h18, "reset flags");
		cmp({ten, tdat}, 8'h00, "reset tracks");
		cmp({1'h0, row, phase}, 8'h01, "reset row phase");
		cmp(loc, 8'h00, "reset location");
		@(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		mon_on <= 1'b1;
		xfer(8'h00, 2'h2, 2'h1);
		xfer(8'h96, 2'h1, 2'h2);
		cmp(8'(expq.size()), 8'h00, "sets missing");
		cmp(8'(rpcs > 2), 8'h01, "gaps seen");
		wrap_up();
	end

	initial
	begin
		#300000;
		errors++;
		wrap_up();
	end

	always @(posedge ref_clk)
	begin
		rnd = $random(seed);
		if (!rst)
		begin
			line <= rnd[0];
			act <= |rnd[2:1];
			wsent <= rnd[6:3];
		end
	end

	always @(posedge ref_clk)
	begin
		if (mon_on)
		begin
			cmp({4'h0, phase}, {4'h0, (pph == cbh_pkg::PH_T11) ? 4'h1 : pph + 4'h1}, "phase");
			cmp({5'h0, alt, rdr, pun}, {5'h0, loc[0], loc < 8'h64, loc >= 8'h64}, "half");
			cmp({7'h0, h2w & rdr & (phase !== cbh_pkg::PH_T1)}, 8'h00, "write half");
			cmp({7'h0, h2w & (phase === cbh_pkg::PH_T2)}, 8'h00, "write restore");
			if (phase === cbh_pkg::PH_T1)
				cmp({h1s, h1e, h2s, h2e, trig, 3'h0}, 8'h00, "read restore");
			if (pw !== 1'b1)
				cmp({ten, tdat}, 8'h00, "idle tracks");
			else
				cmp({ten, tdat}, trk_exp(prow, pact & ~pline & ppun), "tracks");
			if (trig === 1'b1)
			begin
				e = (expq.size() > 0) ? expq.pop_front() : 2'h3;
				cmp({phase, h1s, h1e, h2s, h2e}, {cbh_pkg::PH_T3, e[1], e[1], e[0], e[0]}, "read");
			end
			if (counter_reset_pulse === 1'b1)
			begin
				cmp({2'h0, prow, row}, {2'h0, 3'h0, cbh_pkg::ROW_SIX}, "force row");
				cmp({1'h0, ccs, alt, low, phase}, {4'h7, cbh_pkg::PH_T8 + 4'h1}, "force");
				if (row_ok)
					cmp(8'(steps), 8'h0C, "steps per turn");
				{row_ok, erow, elow, steps} = {1'b1, cbh_pkg::ROW_SIX, 1'b1, 32'd0};
				rpcs++;
			end
			if (pke === 1'b1 && ppke === 1'b0)
				cmp({3'h0, alt, phase}, {4'h1, cbh_pkg::PH_T11}, "sync set");
			if (srp === 1'b1 && row_ok)
			begin
				elow = (erow == 3'h6) ? ~elow : elow;
				erow = (erow == 3'h6) ? 3'h1 : erow + 3'h1;
				steps++;
				cmp({1'h0, row, phase}, {1'h0, erow, cbh_pkg::PH_T11}, "step row");
				cmp({4'h0, alt, low, upp, pke}, {4'h0, 1'b1, elow, ~elow, 1'b0}, "step");
			end
		end
		{pph, pw, prow, pline, pact, ppke, ppun} = {phase, h2w, row, line, act, pke, pun};
	end
endmodule : cbh_card_buffer_tb
